// ---- hdl/dlsa_pkg.sv ----
// holds the register map, field positions and reset values of the
// system access registers; assumes an 8-bit link address space
package dlsa_pkg;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_RESET_REQUEST = 8'h08;
  localparam logic [7:0] OFS_SYSTEM_CONTROL = 8'h0a;
  localparam logic [7:0] OFS_SYSTEM_STATUS = 8'h0b;
  localparam logic [7:0] OFS_CHECKSUM_STATE = 8'h0c;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRL_CLOCK_REQUEST_BIT = 0;
  localparam int CTRL_USER_ROW_DONE_BIT = 1;
  localparam int STAT_LOCKED_BIT = 0;
  localparam int STAT_UROW_READY_BIT = 2;
  localparam int STAT_NVM_READY_BIT = 3;
  localparam int STAT_SLEEPING_BIT = 4;
  localparam int STAT_RESET_ACTIVE_BIT = 5;
  localparam int RSTREQ_ACTIVE_BIT = 0;

  // ----------------------------------------------------------------
  // reset values and codes
  // ----------------------------------------------------------------
  localparam logic [7:0] SYSTEM_CONTROL_RESET = 8'h00;
  localparam logic [7:0] SYSTEM_STATUS_RESET = 8'h01;
  localparam logic [7:0] CHECKSUM_STATE_RESET = 8'h00;
  localparam logic [7:0] RESET_REQUEST_RESET = 8'h00;
  localparam logic [7:0] RESET_SIGNATURE = 8'h59;
  localparam logic [2:0] CRC_OFF = 3'h0;
  localparam logic [2:0] CRC_BUSY = 3'h1;
  localparam logic [2:0] CRC_GOOD = 3'h2;
  localparam logic [2:0] CRC_FAILED = 3'h4;
endpackage

// ---- hdl/dlsa_reset_request.sv ----
// holds the reset-request register of the system access interface
// assumes write strobes are one-cycle pulses on sys_clk
module dlsa_reset_request (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // register write
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  // reset hold towards the system domain
  output logic hold_q
);
  logic hold_d;
  logic sig_match;

  assign sig_match = (wr_data == dlsa_pkg::RESET_SIGNATURE);
  assign hold_d = wr_en ? sig_match : hold_q;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_q <= dlsa_pkg::RESET_REQUEST_RESET[0];
    end else begin
      hold_q <= hold_d;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_sig_asserts: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    wr_en && sig_match |=> hold_q)
    else $error("reset signature did not assert hold");
  a_other_releases: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    wr_en && !sig_match |=> !hold_q)
    else $error("non-signature write did not release hold");
endmodule

// ---- hdl/dlsa_top.sv ----
// holds the system control, system status and checksum state
// registers of the system access interface of the debug link;
// assumes the link layer delivers one-cycle read and write strobes
// synchronous to sys_clk and that all status inputs are synchronous

// Summary of operation
// - accepted done write starts user row copy
// - done write ignored without user row key
// - clock request bit follows host writes
// - link disable clears clock request
// - link enable sets clock request
// - reset active shows system reset
// - reading status clears reset active
// - reset request register sets reset active
// - sleeping bit shows idle or deeper
// - nvm ready shows programming permitted
// - user row ready shows programming permitted
// - locked bit follows lock bits, resets one
// - locked clears after chip erase
// - checksum state is one-hot code, all zero when off
// - signature write holds reset, other releases
module dlsa_top (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // register access from the link layer
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata_q,
  output logic reg_rvalid_q,
  // link and key state
  input wire logic link_enabled,
  input wire logic key_user_row_write,
  // system domain state
  input wire logic sys_in_reset,
  input wire logic sys_sleeping,
  input wire logic nvm_program_permit,
  input wire logic user_row_program_permit,
  input wire logic lock_bits_set,
  input wire logic crc_enabled,
  input wire logic crc_busy,
  input wire logic crc_pass,
  // requests to the system domain
  output logic system_clock_request_q,
  output logic user_row_done_q,
  output logic system_reset_hold_q
);
  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic link_prev_q;
  logic clk_req_d;
  logic urow_bit_q;
  logic urow_bit_d;
  logic urow_pulse_d;
  logic rst_active_q;
  logic rst_active_d;
  logic sleep_q;
  logic nvm_ready_q;
  logic urow_ready_q;
  logic locked_q;
  logic [2:0] crc_q;
  logic [2:0] crc_d;
  logic [7:0] rd_mux;
  logic [7:0] ctrl_view;
  logic [7:0] stat_view;
  logic wr_ctrl;
  logic wr_rstreq;
  logic rd_stat;
  logic link_rise;
  logic urow_accept;
  logic rst_set;

  assign wr_ctrl = reg_wr && (reg_addr == dlsa_pkg::OFS_SYSTEM_CONTROL);
  assign wr_rstreq = reg_wr && (reg_addr == dlsa_pkg::OFS_RESET_REQUEST);
  assign rd_stat = reg_rd && (reg_addr == dlsa_pkg::OFS_SYSTEM_STATUS);
  assign link_rise = link_enabled && !link_prev_q;

  // ----------------------------------------------------------------
  // system control
  // ----------------------------------------------------------------
  // disable clears request
  assign clk_req_d = !link_enabled ? 1'b0 :
                     link_rise ? 1'b1 :
                     wr_ctrl ? reg_wdata[dlsa_pkg::CTRL_CLOCK_REQUEST_BIT] :
                     system_clock_request_q;

  assign urow_accept = wr_ctrl && key_user_row_write && link_enabled;
  assign urow_pulse_d = urow_accept &&
                        reg_wdata[dlsa_pkg::CTRL_USER_ROW_DONE_BIT];
  assign urow_bit_d = !link_enabled ? 1'b0 :
                      urow_accept ?
                      reg_wdata[dlsa_pkg::CTRL_USER_ROW_DONE_BIT] :
                      urow_bit_q;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      link_prev_q <= 1'b0;
      system_clock_request_q <=
        dlsa_pkg::SYSTEM_CONTROL_RESET[dlsa_pkg::CTRL_CLOCK_REQUEST_BIT];
      urow_bit_q <=
        dlsa_pkg::SYSTEM_CONTROL_RESET[dlsa_pkg::CTRL_USER_ROW_DONE_BIT];
      user_row_done_q <= 1'b0;
    end else begin
      link_prev_q <= link_enabled;
      system_clock_request_q <= clk_req_d;
      urow_bit_q <= urow_bit_d;
      user_row_done_q <= urow_pulse_d;
    end
  end

  // ----------------------------------------------------------------
  // reset request register
  // ----------------------------------------------------------------
  dlsa_reset_request u_reset_request (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .wr_en(wr_rstreq),
    .wr_data(reg_wdata),
    .hold_q(system_reset_hold_q)
  );

  // ----------------------------------------------------------------
  // system status and checksum state
  // ----------------------------------------------------------------
  // system reset sets flag
  assign rst_set = sys_in_reset || system_reset_hold_q;
  assign rst_active_d = rst_set ? 1'b1 : (rd_stat ? 1'b0 : rst_active_q);

  assign crc_d = !crc_enabled ? dlsa_pkg::CRC_OFF :
                 crc_busy ? dlsa_pkg::CRC_BUSY :
                 crc_pass ? dlsa_pkg::CRC_GOOD : dlsa_pkg::CRC_FAILED;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_active_q <=
        dlsa_pkg::SYSTEM_STATUS_RESET[dlsa_pkg::STAT_RESET_ACTIVE_BIT];
      sleep_q <= dlsa_pkg::SYSTEM_STATUS_RESET[dlsa_pkg::STAT_SLEEPING_BIT];
      nvm_ready_q <=
        dlsa_pkg::SYSTEM_STATUS_RESET[dlsa_pkg::STAT_NVM_READY_BIT];
      urow_ready_q <=
        dlsa_pkg::SYSTEM_STATUS_RESET[dlsa_pkg::STAT_UROW_READY_BIT];
      locked_q <= dlsa_pkg::SYSTEM_STATUS_RESET[dlsa_pkg::STAT_LOCKED_BIT];
      crc_q <= dlsa_pkg::CHECKSUM_STATE_RESET[2:0];
    end else begin
      rst_active_q <= rst_active_d;
      sleep_q <= sys_sleeping;
      nvm_ready_q <= nvm_program_permit;
      urow_ready_q <= user_row_program_permit;
      locked_q <= lock_bits_set;
      crc_q <= crc_d;
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  assign ctrl_view = {6'h00, urow_bit_q, system_clock_request_q};
  assign stat_view = {2'h0, rst_active_q, sleep_q, nvm_ready_q,
                      urow_ready_q, 1'b0, locked_q};
  assign rd_mux =
    (reg_addr == dlsa_pkg::OFS_SYSTEM_CONTROL) ? ctrl_view :
    (reg_addr == dlsa_pkg::OFS_SYSTEM_STATUS) ? stat_view :
    (reg_addr == dlsa_pkg::OFS_CHECKSUM_STATE) ? {5'h00, crc_q} :
    (reg_addr == dlsa_pkg::OFS_RESET_REQUEST) ?
      {7'h00, system_reset_hold_q} : 8'h00;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_q <= 8'h00;
      reg_rvalid_q <= 1'b0;
    end else begin
      reg_rvalid_q <= reg_rd;
      if (reg_rd) begin
        reg_rdata_q <= rd_mux;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_system_clock_request_disable: assert property (
    !link_enabled |=> !system_clock_request_q)
    else $error("clock request not cleared on link disable");
  a_system_clock_request_enable: assert property (
    link_enabled && !link_prev_q |=> system_clock_request_q)
    else $error("clock request not set on link enable");
  a_system_clock_request_write: assert property (
    wr_ctrl && link_enabled && link_prev_q |=>
    system_clock_request_q == $past(reg_wdata[0]))
    else $error("clock request does not follow write");
  // a link disable in the same cycle may still clear the stored bit
  a_urow_nokey: assert property (
    wr_ctrl && !key_user_row_write |=> !user_row_done_q &&
    ($stable(urow_bit_q) || !$past(link_enabled)))
    else $error("user row done accepted without key");
  a_urow_start: assert property (
    wr_ctrl && key_user_row_write && link_enabled && reg_wdata[1] |=>
    user_row_done_q ##1 !user_row_done_q || $past(urow_pulse_d))
    else $error("user row copy not started");
  a_rst_active_set: assert property (
    sys_in_reset |=> rst_active_q)
    else $error("reset active not shown");
  a_rst_read_clear: assert property (
    rd_stat && !rst_set ##1 !rst_set |=> !rst_active_q)
    else $error("reset active not cleared by read");
  a_rst_request_seen: assert property (
    system_reset_hold_q |=> rst_active_q)
    else $error("reset request not reflected");
  a_sleep_read: assert property (
    sys_sleeping ##1 (rd_stat && sys_sleeping) |=> reg_rdata_q[4])
    else $error("sleeping bit wrong on read");
  a_ready_bits: assert property (
    ##1 nvm_ready_q == $past(nvm_program_permit) &&
    urow_ready_q == $past(user_row_program_permit))
    else $error("ready bits do not follow permits");
  a_lock_after_erase: assert property (
    !lock_bits_set [*2] |-> !locked_q)
    else $error("locked bit still set after erase");
  a_crc_onehot: assert property (
    $onehot0(crc_q) && (!$past(crc_enabled) -> crc_q == 3'h0))
    else $error("checksum state not one-hot");

  c_urow_done: cover property (wr_ctrl && key_user_row_write ##1
    user_row_done_q);
  c_status_clear: cover property (rst_active_q && rd_stat ##1 !rst_active_q);
  c_crc_fail: cover property (crc_q == dlsa_pkg::CRC_BUSY ##[1:20]
    crc_q == dlsa_pkg::CRC_FAILED);
  c_link_cycle: cover property (link_rise ##[1:20] !link_enabled);
endmodule

// ---- tb/dlsa_host_model.sv ----
// host tool model: drives the register strobes of the access interface
// assumes one-cycle strobes sampled on the rising edge of sys_clk
module dlsa_host_model (
  // clock
  input wire logic sys_clk,
  // register bus towards the block
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata_q,
  input wire logic reg_rvalid_q
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // bus cycles
  // ----------------------------------------------------------------
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    // released data must not keep showing the last value
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    d = 8'hxx;
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      #1;
      if (reg_rvalid_q === 1'b1) begin
        d = reg_rdata_q;
        break;
      end
      @(posedge sys_clk);
    end
  endtask
  // done bit and clock request sent in one control write
  task automatic urow_finish();
    // keeps the clock request up while signalling done
    wr(8'h0a, 8'h03);
  endtask
  task automatic nvm_finish();
    wr(8'h08, 8'h59);
  endtask
endmodule

// ---- tb/tb_dlsa_top.sv ----
// self-checking bench for the system access registers
// assumes the host model owns the register strobes
module tb_dlsa_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata_q, rd_v;
  logic reg_wr, reg_rd, reg_rvalid_q, clk_req, done, hold;
  logic link_enabled = 1'b0;
  logic key = 1'b0;
  logic sys_in_reset = 1'b0;
  logic sleeping = 1'b0;
  logic nvm_ok = 1'b0;
  logic urow_ok = 1'b0;
  logic lock = 1'b1;
  logic crc_enabled = 1'b0;
  logic crc_busy = 1'b0;
  logic crc_pass = 1'b0;
  int failures = 0;
  int checks = 0;
  int done_cnt = 0;
  always #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (done === 1'b1) done_cnt++;
  dlsa_host_model host_u (.sys_clk(sys_clk), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q));
  dlsa_top dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q),
    .link_enabled(link_enabled), .key_user_row_write(key),
    .sys_in_reset(sys_in_reset), .sys_sleeping(sleeping),
    .nvm_program_permit(nvm_ok), .user_row_program_permit(urow_ok),
    .lock_bits_set(lock), .crc_enabled(crc_enabled), .crc_busy(crc_busy),
    .crc_pass(crc_pass), .system_clock_request_q(clk_req),
    .user_row_done_q(done), .system_reset_hold_q(hold));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    host_u.rd(a, rd_v);
    chk(rd_v, exp);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic wrap_up();
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rchk(8'h0b, 8'h01);
    rchk(8'h0a, 8'h00);
    rchk(8'h0c, 8'h00);
    rchk(8'h08, 8'h00);
    rchk(8'h0f, 8'h00);
    $display("test reset values done");
  endtask
  task automatic t_clock();
    host_u.wr(8'h0a, 8'h01);
    rchk(8'h0a, 8'h00);
    @(posedge sys_clk) link_enabled <= 1'b1;
    tick(2);
    chk({7'h00, clk_req}, 8'h01);
    host_u.wr(8'h0a, 8'h00);
    tick(1);
    chk({7'h00, clk_req}, 8'h00);
    host_u.wr(8'h0a, 8'h01);
    tick(1);
    chk({7'h00, clk_req}, 8'h01);
    @(posedge sys_clk) link_enabled <= 1'b0;
    tick(2);
    chk({7'h00, clk_req}, 8'h00);
    @(posedge sys_clk) link_enabled <= 1'b1;
    tick(2);
    $display("test clock request done");
  endtask
  task automatic t_urow();
    host_u.urow_finish();
    tick(2);
    chk(done_cnt[7:0], 8'h00);
    rchk(8'h0a, 8'h01);
    @(posedge sys_clk) key <= 1'b1;
    host_u.urow_finish();
    tick(3);
    chk(done_cnt[7:0], 8'h01);
    rchk(8'h0a, 8'h03);
    $display("test user row done");
  endtask
  task automatic t_status();
    @(posedge sys_clk) begin
      sleeping <= 1'b1;
      nvm_ok <= 1'b1;
      urow_ok <= 1'b1;
      lock <= 1'b0;
    end
    tick(2);
    rchk(8'h0b, 8'h1c);
    @(posedge sys_clk) begin
      sleeping <= 1'b0;
      nvm_ok <= 1'b0;
      urow_ok <= 1'b0;
      lock <= 1'b1;
    end
    tick(2);
    rchk(8'h0b, 8'h01);
    $display("test status done");
  endtask
  task automatic t_sysreset();
    @(posedge sys_clk) sys_in_reset <= 1'b1;
    @(posedge sys_clk) sys_in_reset <= 1'b0;
    tick(2);
    rchk(8'h0b, 8'h21);
    rchk(8'h0b, 8'h01);
    host_u.nvm_finish();
    tick(1);
    chk({7'h00, hold}, 8'h01);
    rchk(8'h0b, 8'h21);
    rchk(8'h0b, 8'h21);
    rchk(8'h08, 8'h01);
    host_u.wr(8'h08, 8'h58);
    tick(1);
    chk({7'h00, hold}, 8'h00);
    rchk(8'h0b, 8'h21);
    rchk(8'h0b, 8'h01);
    $display("test system reset done");
  endtask
  task automatic t_crc();
    logic [2:0] tab_in [4] = '{3'b000, 3'b110, 3'b101, 3'b100};
    logic [7:0] tab_ex [4] = '{8'h00, 8'h01, 8'h02, 8'h04};
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk) {crc_enabled, crc_busy, crc_pass} <= tab_in[i];
      tick(2);
      rchk(8'h0c, tab_ex[i]);
    end
    $display("test checksum state done");
  endtask
  initial begin
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    tick(2);
    t_reset();
    t_clock();
    t_urow();
    t_status();
    t_sysreset();
    t_crc();
    wrap_up();
  end
  initial begin
    repeat (6000) @(posedge sys_clk);
    failures++;
    wrap_up();
  end
endmodule
